//--- urs_defines.svh
// register offsets, field positions and reset values for the quad channel
// reset-state bank; included by the package and every design module.
// Functional notes
// - each channel has an 8-bit scratch register that software writes and reads back, with no effect on the channel.
// - external reset clears irq enable, line control, modem control and fifo control registers to zero.
// - external reset leaves irq status at zero except bit 0, which reads one for no interrupt pending.
// - external reset loads line status with bits 6 and 5 set and all other bits clear.
// - external reset clears the four modem change bits while the upper four keep following the modem inputs.
// - request-to-send of every channel stays high, its inactive level, during and after reset.
// - data-terminal-ready of every channel stays high, its inactive level, during and after reset.
// - reset drives every serial output high, the receive dma request high and the transmit dma request low.
// - reading modem status clears the change bits; each bit sets when its modem input changes, the ring bit only on its trailing edge.
// - outside loopback each upper modem status bit is the complement of its active-low input pin.
`ifndef URS_DEFINES_SVH
`define URS_DEFINES_SVH

// register index within a channel; byte address = {ch, idx, 2'b00}
`define URS_IDX_IER 3'h0
`define URS_IDX_ISR 3'h1
`define URS_IDX_FCR 3'h2
`define URS_IDX_LCR 3'h3
`define URS_IDX_MCR 3'h4
`define URS_IDX_LSR 3'h5
`define URS_IDX_MSR 3'h6
`define URS_IDX_SCR 3'h7
`define URS_ADDR_TOP 7

// reset values
`define URS_RST_IER 8'h00
`define URS_RST_LCR 8'h00
`define URS_RST_MCR 8'h00
`define URS_RST_FCR 8'h00
`define URS_RST_ISR 8'h01
`define URS_RST_LSR 8'h60
`define URS_RST_SCR 8'h00

// field positions
`define URS_MCR_DTR   0
`define URS_MCR_RTS   1
`define URS_MCR_OP1   2
`define URS_MCR_OP2   3
`define URS_MCR_LOOP  4
`define URS_LCR_BREAK 6
`define URS_IER_MODEM 3
`define URS_FCR_EN    0

// bus answers
`define URS_RESP_OKAY   2'h0
`define URS_RESP_SLVERR 2'h2

`endif

//--- urs_pkg.sv
// types shared by the channel and the bus-facing top of the reset bank
// assumes urs_defines.svh is reachable on the include path
`include "urs_defines.svh"
package urs_pkg;

  typedef enum logic [2:0] {
    URS_R_IER = 3'b000,
    URS_R_ISR = 3'b001,
    URS_R_FCR = 3'b010,
    URS_R_LCR = 3'b011,
    URS_R_MCR = 3'b100,
    URS_R_LSR = 3'b101,
    URS_R_MSR = 3'b110,
    URS_R_SCR = 3'b111
  } urs_reg_idx_t;

  // whole state of one channel
  typedef struct packed {
    logic [7:0] irq_enable_reg;
    logic [7:0] line_control_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] fifo_control_reg;
    logic [7:0] scr;
    logic [7:0] line_status_reg;
    logic [3:0] delta;
    logic [3:0] prev;
    logic       primed;
  } urs_chan_st_t;

  // whole state of the bus slave
  typedef struct packed {
    logic       aw_got;
    logic       aw_ok;
    logic [4:0] aw_idx;
    logic       w_got;
    logic       w_en;
    logic [7:0] w_data;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic       rx_dma;
    logic       tx_dma;
  } urs_bus_st_t;

endpackage : urs_pkg

//--- urs_chan.sv
// one serial channel: control/status registers, modem status, pin levels
// assumes a host slave that issues at most one write and one read per cycle
`timescale 1ns/1ps
`include "urs_defines.svh"
module urs_chan (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                wr_en,
  input  wire urs_pkg::urs_reg_idx_t wr_idx,
  input  wire logic [7:0]          wr_data,
  input  wire urs_pkg::urs_reg_idx_t rd_idx,
  input  wire logic                rd_clr,
  input  wire logic [3:0]          modem_n,
  output logic [7:0]               rd_val,
  output logic                     serial_out,
  output logic                     req_send_out,
  output logic                     term_ready_out
);
  import urs_pkg::*;

  localparam urs_chan_st_t RST = '{irq_enable_reg: `URS_RST_IER, line_control_reg: `URS_RST_LCR,
    modem_control_reg: `URS_RST_MCR, fifo_control_reg: `URS_RST_FCR, scr: `URS_RST_SCR,
    line_status_reg: `URS_RST_LSR, delta: 4'h0, prev: 4'h0, primed: 1'b0};

  urs_chan_st_t q, d;
  logic [3:0]   msr_hi;
  logic [3:0]   set_v;
  logic [7:0]   irq_status_reg;
  logic         loop;

  // modem status upper nibble, loopback routes control bits back
  always_comb begin
    loop = q.modem_control_reg[`URS_MCR_LOOP];
    if (loop) begin
      msr_hi = {q.modem_control_reg[`URS_MCR_OP2], q.modem_control_reg[`URS_MCR_OP1],
                q.modem_control_reg[`URS_MCR_DTR], q.modem_control_reg[`URS_MCR_RTS]};
    end else begin
      msr_hi = ~modem_n;
    end
    // ri flags only its trailing edge; first cycle after reset is skipped
    set_v = q.primed ? {msr_hi[3] ^ q.prev[3], q.prev[2] & ~msr_hi[2],
                        msr_hi[1:0] ^ q.prev[1:0]} : 4'h0;
    irq_status_reg = {q.fifo_control_reg[`URS_FCR_EN], q.fifo_control_reg[`URS_FCR_EN], 5'h00,
           ~(q.irq_enable_reg[`URS_IER_MODEM] & (|q.delta))};
  end

  // next state: writes, change capture, set beats read clear
  always_comb begin
    d        = q;
    d.prev   = msr_hi;
    d.primed = 1'b1;
    d.delta  = (q.delta & ~{4{rd_clr}}) | set_v;
    if (wr_en) begin
      case (wr_idx)
        URS_R_IER: d.irq_enable_reg = wr_data;
        URS_R_FCR: d.fifo_control_reg = wr_data;
        URS_R_LCR: d.line_control_reg = wr_data;
        URS_R_MCR: d.modem_control_reg = wr_data;
        URS_R_SCR: d.scr = wr_data;
        default:   d.irq_enable_reg = q.irq_enable_reg; // status registers ignore writes
      endcase
    end
  end

  // asynchronous reset to constants only
  always_ff @(posedge aclk or negedge aresetn) begin
    if (!aresetn) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // read mux
  always_comb begin
    case (rd_idx)
      URS_R_IER: rd_val = q.irq_enable_reg;
      URS_R_ISR: rd_val = irq_status_reg;
      URS_R_FCR: rd_val = q.fifo_control_reg;
      URS_R_LCR: rd_val = q.line_control_reg;
      URS_R_MCR: rd_val = q.modem_control_reg;
      URS_R_LSR: rd_val = q.line_status_reg;
      URS_R_MSR: rd_val = {msr_hi, q.delta};
      URS_R_SCR: rd_val = q.scr;
      default:   rd_val = 8'h00;
    endcase
  end

  // pins idle high; loopback keeps them inactive
  assign serial_out     = ~(q.line_control_reg[`URS_LCR_BREAK] & ~loop);
  assign req_send_out   = ~(q.modem_control_reg[`URS_MCR_RTS] & ~loop);
  assign term_ready_out = ~(q.modem_control_reg[`URS_MCR_DTR] & ~loop);

  sequence s_cts_change;
    q.primed && (msr_hi[0] != q.prev[0]) && !rd_clr;
  endsequence

  chk_ctl_reset_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> (q.irq_enable_reg | q.line_control_reg | q.modem_control_reg | q.fifo_control_reg) == 8'h00)
    else $error("control register not zero after reset");
  chk_isr_reset_val: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> irq_status_reg == 8'h01)
    else $error("irq status not 01 after reset");
  chk_lsr_reset_val: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> q.line_status_reg == 8'h60)
    else $error("line status not 60 after reset");
  chk_delta_reset_clr: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> q.delta == 4'h0 ##1 q.delta == 4'h0)
    else $error("modem change bits set right after reset");
  chk_msr_read_clr: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_clr && set_v == 4'h0) |=> q.delta == 4'h0)
    else $error("modem change bits survive a read");
  chk_cts_delta_set: assert property (@(posedge aclk) disable iff (!aresetn)
    s_cts_change |=> q.delta[0])
    else $error("cts change not flagged");
  chk_msr_pin_copy: assert property (@(posedge aclk) disable iff (!aresetn)
    (!loop && rd_idx == URS_R_MSR) |-> rd_val[7:4] == ~modem_n)
    else $error("modem status does not mirror inputs");
  chk_scratch_back: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_en && wr_idx == URS_R_SCR) |=> q.scr == $past(wr_data))
    else $error("scratch lost written value");

endmodule : urs_chan

//--- urs_top.sv
// four-channel reset-state register bank behind an axi4-lite slave
// assumes one clock, modem inputs synchronous to aclk, 32-bit data bus
`timescale 1ns/1ps
`include "urs_defines.svh"
module urs_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // active-low modem inputs, bit n is channel n
  input  wire logic [3:0]  clr_send_in_n,
  input  wire logic [3:0]  set_ready_in_n,
  input  wire logic [3:0]  ring_in_n,
  input  wire logic [3:0]  carrier_in_n,
  // serial line outputs
  output logic             serial_out_ch0,
  output logic             serial_out_ch1,
  output logic             serial_out_ch2,
  output logic             serial_out_ch3,
  // modem control outputs, active low
  output logic             req_send_out_ch0,
  output logic             req_send_out_ch1,
  output logic             req_send_out_ch2,
  output logic             req_send_out_ch3,
  output logic             term_ready_out_ch0,
  output logic             term_ready_out_ch1,
  output logic             term_ready_out_ch2,
  output logic             term_ready_out_ch3,
  // dma ready outputs
  output logic             rx_dma_request,
  output logic             tx_dma_request
);
  import urs_pkg::*;

  localparam urs_bus_st_t RST = '{aw_got: 1'b0, aw_ok: 1'b0, aw_idx: 5'h00,
    w_got: 1'b0, w_en: 1'b0, w_data: 8'h00, bvalid: 1'b0,
    bresp: `URS_RESP_OKAY, rvalid: 1'b0, rresp: `URS_RESP_OKAY,
    rdata: 8'h00, rx_dma: 1'b1, tx_dma: 1'b0};

  urs_bus_st_t q, d;

  logic         aw_hs;
  logic         w_hs;
  logic         ar_hs;
  logic         wr_go;
  logic         wr_ok;
  logic [4:0]   wr_sel;
  logic         wr_lane;
  logic [7:0]   wr_byte;
  logic         ar_ok;
  logic [4:0]   ar_sel;
  logic [3:0]   ch_wr;
  logic [3:0]   ch_clr;
  logic [7:0]   ch_rd [4];
  logic [3:0]   ser;
  logic [3:0]   rts;
  logic [3:0]   dtr;
  urs_reg_idx_t wr_reg;
  urs_reg_idx_t ar_reg;

  // ready terms: one write and one read in flight at a time
  assign s_axi_awready = ~q.aw_got & ~q.bvalid;
  assign s_axi_wready  = ~q.w_got & ~q.bvalid;
  assign s_axi_arready = ~q.rvalid;
  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs  = s_axi_wvalid & s_axi_wready;
  assign ar_hs = s_axi_arvalid & s_axi_arready;

  // address decode; the prot fields carry no meaning here
  assign ar_ok  = (s_axi_araddr[31:`URS_ADDR_TOP] == 25'h0000000);
  assign ar_sel = s_axi_araddr[6:2];
  assign ar_reg = urs_reg_idx_t'(ar_sel[2:0]);

  // write address and data may arrive in either order
  always_comb begin
    if (q.aw_got) begin
      wr_ok  = q.aw_ok;
      wr_sel = q.aw_idx;
    end else begin
      wr_ok  = (s_axi_awaddr[31:`URS_ADDR_TOP] == 25'h0000000);
      wr_sel = s_axi_awaddr[6:2];
    end
    if (q.w_got) begin
      wr_lane = q.w_en;
      wr_byte = q.w_data;
    end else begin
      wr_lane = s_axi_wstrb[0];
      wr_byte = s_axi_wdata[7:0];
    end
    wr_go  = (q.aw_got | aw_hs) & (q.w_got | w_hs);
    wr_reg = urs_reg_idx_t'(wr_sel[2:0]);
  end

  // per-channel write strobes and status-read clear pulses
  always_comb begin
    ch_wr  = 4'h0;
    ch_clr = 4'h0;
    if (wr_go && wr_ok && wr_lane) begin
      ch_wr[wr_sel[4:3]] = 1'b1;
    end
    if (ar_hs && ar_ok && ar_reg == URS_R_MSR) begin
      ch_clr[ar_sel[4:3]] = 1'b1;
    end
  end

  // next state of the slave
  always_comb begin
    d = q;
    if (aw_hs && !wr_go) begin
      d.aw_got = 1'b1;
      d.aw_ok  = wr_ok;
      d.aw_idx = wr_sel;
    end
    if (w_hs && !wr_go) begin
      d.w_got  = 1'b1;
      d.w_en   = wr_lane;
      d.w_data = wr_byte;
    end
    if (wr_go) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = wr_ok ? `URS_RESP_OKAY : `URS_RESP_SLVERR;
    end else if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // read answers one cycle after the address is taken
    if (ar_hs) begin
      d.rvalid = 1'b1;
      d.rresp  = ar_ok ? `URS_RESP_OKAY : `URS_RESP_SLVERR;
      d.rdata  = ar_ok ? ch_rd[ar_sel[4:3]] : 8'h00;
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    // no receive or transmit path: dma levels stay at their idle values
    d.rx_dma = 1'b1;
    d.tx_dma = 1'b0;
  end

  // asynchronous reset to constants only
  always_ff @(posedge aclk or negedge aresetn) begin
    if (!aresetn) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // bus outputs straight from registers, upper bytes read as zero
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp  = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp  = q.rresp;
  assign s_axi_rdata  = {24'h000000, q.rdata};
  assign rx_dma_request = q.rx_dma;
  assign tx_dma_request = q.tx_dma;

  // one channel per generate pass, all on the same reset
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      urs_chan u_chan (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .wr_en          (ch_wr[gi]),
        .wr_idx         (wr_reg),
        .wr_data        (wr_byte),
        .rd_idx         (ar_reg),
        .rd_clr         (ch_clr[gi]),
        .modem_n        ({carrier_in_n[gi], ring_in_n[gi],
                          set_ready_in_n[gi], clr_send_in_n[gi]}),
        .rd_val         (ch_rd[gi]),
        .serial_out     (ser[gi]),
        .req_send_out   (rts[gi]),
        .term_ready_out (dtr[gi])
      );
    end
  endgenerate

  // pin fan-out
  assign serial_out_ch0     = ser[0];
  assign serial_out_ch1     = ser[1];
  assign serial_out_ch2     = ser[2];
  assign serial_out_ch3     = ser[3];
  assign req_send_out_ch0   = rts[0];
  assign req_send_out_ch1   = rts[1];
  assign req_send_out_ch2   = rts[2];
  assign req_send_out_ch3   = rts[3];
  assign term_ready_out_ch0 = dtr[0];
  assign term_ready_out_ch1 = dtr[1];
  assign term_ready_out_ch2 = dtr[2];
  assign term_ready_out_ch3 = dtr[3];

  // helper view of the pin groups for the checks below
  logic [3:0] rts_pins;
  logic [3:0] dtr_pins;
  logic [3:0] ser_pins;
  assign rts_pins = {req_send_out_ch3, req_send_out_ch2,
                     req_send_out_ch1, req_send_out_ch0};
  assign dtr_pins = {term_ready_out_ch3, term_ready_out_ch2,
                     term_ready_out_ch1, term_ready_out_ch0};
  assign ser_pins = {serial_out_ch3, serial_out_ch2,
                     serial_out_ch1, serial_out_ch0};

  sequence s_wr_pair;
    wr_go && wr_ok && wr_lane && wr_reg == URS_R_SCR;
  endsequence

  sequence s_rd_same;
    ar_hs && ar_ok && ar_reg == URS_R_SCR;
  endsequence

  chk_rts_reset_high: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> rts_pins == 4'hF [*2])
    else $error("request-to-send not high after reset");
  chk_dtr_reset_high: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> dtr_pins == 4'hF [*2])
    else $error("terminal-ready not high after reset");
  chk_pins_reset_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> ser_pins == 4'hF && rx_dma_request
                        && !tx_dma_request)
    else $error("serial or dma pins not idle after reset");
  chk_dma_levels_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> rx_dma_request && !tx_dma_request)
    else $error("dma levels moved");
  chk_scratch_readback: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (s_wr_pair and !ar_hs) ##1 !wr_go [*2] ##1
    (s_rd_same and (ar_sel == $past(wr_sel, 3) && !wr_go))
    |=> s_axi_rdata[7:0] == $past(wr_byte, 4))
    else $error("scratch readback differs from write");
  chk_bus_idle_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid)
    else $error("bus answer pending after reset");
  chk_wr_resp_time: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid && s_axi_bresp == $past(wr_ok ? 2'h0 : 2'h2))
    else $error("write answer late or wrong");
  chk_rd_resp_time: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs |=> s_axi_rvalid && (s_axi_rdata[31:8] == 24'h000000))
    else $error("read answer late or upper bits set");
  chk_msr_clear_pulse: assert property (@(posedge aclk)
    disable iff (!aresetn)
    |ch_clr |-> ar_hs && ar_reg == URS_R_MSR)
    else $error("modem change clear without a status read");

endmodule : urs_top

//--- urs_modem_model.sv
// partner model: the modem cables seen by the four channels
// assumes the bench sets the wanted levels just after a rising aclk edge
`timescale 1ns/1ps
module urs_modem_model (
  input  wire logic        aclk,
  input  wire logic [15:0] lvl,
  output logic [3:0]       clr_send_n,
  output logic [3:0]       set_ready_n,
  output logic [3:0]       ring_n,
  output logic [3:0]       carrier_n
);
  // nibble c of lvl is {carrier, ring, set_ready, clr_send} of channel c
  logic [15:0] pin_q = 16'hFFFF;

  // pins follow one edge late, as a real cable would
  always_ff @(posedge aclk) begin
    pin_q <= lvl;
  end

  // unpack per channel
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      clr_send_n[c]  = pin_q[4*c];
      set_ready_n[c] = pin_q[4*c+1];
      ring_n[c]      = pin_q[4*c+2];
      carrier_n[c]   = pin_q[4*c+3];
    end
  end
endmodule : urs_modem_model

//--- uart_channel_reset_state_tb.sv
// self-checking bench for the four-channel reset-state register bank
// assumes urs_top, urs_pkg, urs_defines.svh and urs_modem_model are compiled
`timescale 1ns/1ps
`include "urs_defines.svh"
module uart_channel_reset_state_tb;
  logic        aclk;
  logic        aresetn;
  logic [31:0] awaddr;
  logic [31:0] wdata;
  logic [31:0] araddr;
  logic [31:0] rdata;
  logic [31:0] got;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  cts_n, dsr_n, ri_n, cd_n, ser, rts, dtr;
  logic        rx_dma, tx_dma;
  logic [15:0] modem;
  int          err_total, total_checks;
  // channel 1 modem steps and the status expected before/after each read
  logic [3:0]  lv[4] = '{4'h2, 4'h6, 4'h2, 4'h3};
  logic [7:0]  e1[4] = '{8'hD8, 8'h94, 8'hD0, 8'hC1};
  logic [7:0]  e2[4] = '{8'hD0, 8'h90, 8'hD0, 8'hC0};

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // prot inputs tied, everything else driven
  urs_top dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .clr_send_in_n(cts_n), .set_ready_in_n(dsr_n),
    .ring_in_n(ri_n), .carrier_in_n(cd_n),
    .serial_out_ch0(ser[0]), .serial_out_ch1(ser[1]),
    .serial_out_ch2(ser[2]), .serial_out_ch3(ser[3]),
    .req_send_out_ch0(rts[0]), .req_send_out_ch1(rts[1]),
    .req_send_out_ch2(rts[2]), .req_send_out_ch3(rts[3]),
    .term_ready_out_ch0(dtr[0]), .term_ready_out_ch1(dtr[1]),
    .term_ready_out_ch2(dtr[2]), .term_ready_out_ch3(dtr[3]),
    .rx_dma_request(rx_dma), .tx_dma_request(tx_dma)
  );

  // far side: modem pins
  urs_modem_model modem_u (
    .aclk(aclk), .lvl(modem), .clr_send_n(cts_n),
    .set_ready_n(dsr_n), .ring_n(ri_n), .carrier_n(cd_n)
  );

  // verdict and end of run, the only exit
  task automatic end_of_test();
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // one compare, four-state exact
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // axi4-lite write; each channel released at the edge it is taken
  task automatic axi_wr(input logic [31:0] a, input logic [7:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    logic aw, w, b;
    bit   done;
    done = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      // handshakes judged on values that stand until the next edge
      @(negedge aclk);
      aw = awvalid & awready;
      w  = wvalid & wready;
      b  = bvalid & bready;
      r  = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
      done = b;
    end
    if (!done) begin
      chk(32'h0, 32'h1);
      end_of_test();
    end
  endtask : axi_wr

  // axi4-lite read, same sampling scheme
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ar, rr;
    bit   done;
    done = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(negedge aclk);
      ar = arvalid & arready;
      rr = rvalid & rready;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
      if (rr) rready <= 1'b0;
      done = rr;
    end
    if (!done) begin
      chk(32'h0, 32'h1);
      end_of_test();
    end
  endtask : axi_rd

  // read one register and expect an okay answer with value e
  task automatic rchk(input logic [31:0] a, input logic [7:0] e);
    axi_rd(a, got, resp);
    chk({30'h0, resp}, {30'h0, `URS_RESP_OKAY});
    chk(got, {24'h0, e});
  endtask : rchk

  // byte address of register i in channel c
  function automatic logic [31:0] adr(input int c, input logic [2:0] i);
    adr = {25'h0, c[1:0], i, 2'b00};
  endfunction : adr

  // value every register must hold right after reset
  function automatic logic [7:0] rv(input int c, input int i);
    case (i)
      1:       rv = 8'h01;
      5:       rv = 8'h60;
      6:       rv = {~modem[4*c+:4], 4'h0};
      default: rv = 8'h00;
    endcase
  endfunction : rv

  // sweep all registers of all channels
  task automatic chk_all();
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 8; i++) begin
        rchk(adr(c, i[2:0]), rv(c, i));
      end
    end
  endtask : chk_all

  // pin levels; rx dma request high and tx dma request low at all times here
  task automatic pins(input logic [3:0] s, input logic [3:0] r,
                      input logic [3:0] d);
    chk({18'h0, ser, rts, dtr, rx_dma, tx_dma}, {18'h0, s, r, d, 2'b10});
  endtask : pins

  // main sequence
  initial begin
    err_total = 0;
    total_checks = 0;
    aresetn = 1'b0;
    {awaddr, wdata, araddr, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    modem = 16'h05AF;
    repeat (7) @(posedge aclk);
    #1 pins(4'hF, 4'hF, 4'hF);
    @(posedge aclk);
    aresetn <= 1'b1;
    chk_all();
    // scratch: all ones, then a per-channel pattern
    for (int c = 0; c < 4; c++) begin
      axi_wr(adr(c, 7), 8'hFF, 4'h1, resp);
      rchk(adr(c, 7), 8'hFF);
      axi_wr(adr(c, 7), {4'hA, c[3:0]}, 4'h1, resp);
    end
    for (int c = 0; c < 4; c++) rchk(adr(c, 7), {4'hA, c[3:0]});
    axi_wr(adr(0, 7), 8'h33, 4'h0, resp);
    rchk(adr(0, 7), 8'hA0);
    axi_wr(adr(0, 5), 8'hFF, 4'h1, resp);
    rchk(adr(0, 5), 8'h60);
    // unmapped address refused both ways
    axi_rd(32'h80, got, resp);
    chk({30'h0, resp}, {30'h0, `URS_RESP_SLVERR});
    chk(got, 32'h0);
    axi_wr(32'h80, 8'h11, 4'h1, resp);
    chk({30'h0, resp}, {30'h0, `URS_RESP_SLVERR});
    // modem edges on channel 1; ring only flags its trailing edge
    for (int k = 0; k < 4; k++) begin
      @(posedge aclk);
      modem[7:4] <= lv[k];
      repeat (4) @(posedge aclk);
      rchk(adr(1, 6), e1[k]);
      rchk(adr(1, 6), e2[k]);
    end
    // leave a carrier change pending on channel 3 for the reset to clear
    @(posedge aclk);
    modem[15:12] <= 4'h8;
    axi_wr(adr(2, 4), 8'h03, 4'h1, resp);
    axi_wr(adr(3, 3), 8'h40, 4'h1, resp);
    axi_wr(adr(0, 0), 8'h0F, 4'h1, resp);
    axi_wr(adr(1, 2), 8'h01, 4'h1, resp);
    #1 pins(4'h7, 4'hB, 4'hB);
    rchk(adr(0, 0), 8'h0F);
    rchk(adr(3, 3), 8'h40);
    // loopback on channel 0: pins stay inactive, status follows control
    axi_wr(adr(0, 4), 8'h13, 4'h1, resp);
    #1 pins(4'h7, 4'hB, 4'hB);
    rchk(adr(0, 6), 8'h33);
    // reset in mid-run must act before the next edge and hold
    @(posedge aclk);
    aresetn <= 1'b0;
    #1 pins(4'hF, 4'hF, 4'hF);
    repeat (8) @(posedge aclk);
    #1 pins(4'hF, 4'hF, 4'hF);
    @(posedge aclk);
    aresetn <= 1'b1;
    chk_all();
    end_of_test();
  end
endmodule : uart_channel_reset_state_tb
